// ### psl_consts.vh
`ifndef PSL_CONSTS_VH
`define PSL_CONSTS_VH

// ==========================================================
// Register offsets
`define PSL_ADDR_PORT_EN     16'h3c48
`define PSL_ADDR_GLOBAL_EN   16'h4141
`define PSL_ADDR_P5_PINSEL   16'h416e
`define PSL_ADDR_P6_PINSEL   16'h416f
`define PSL_ADDR_TIMEOUT     16'h4171
`define PSL_ADDR_LOW_TIME    16'h4176

// ==========================================================
// Reset values and writable masks
`define PSL_RST_PORT_EN      8'h00
`define PSL_RST_GLOBAL_EN    8'h00
`define PSL_RST_PINSEL       8'h00
`define PSL_RST_TIMEOUT      8'h05
`define PSL_RST_LOW_TIME     8'h05
`define PSL_MASK_PORT_EN     8'h60
`define PSL_MASK_GLOBAL_EN   8'h01
`define PSL_MASK_TIMEOUT     8'h07

// ==========================================================
// Field positions
`define PSL_BIT_PORT5        5
`define PSL_BIT_PORT6        6
`define PSL_BIT_GLOBAL       0

// ==========================================================
// Pin selection codes
`define PSL_P5_SEL_A         8'h42
`define PSL_P5_SEL_B         8'h05
`define PSL_P6_SEL_A         8'h06
`define PSL_P6_SEL_B         8'h04

// ==========================================================
// Link states counted as not operational
`define PSL_STUCK_LO         4'h4
`define PSL_STUCK_HI         4'h9

// ==========================================================
// Timeout codes and their times in ms
`define PSL_TO_OFF           3'b000
`define PSL_TO_100           3'b001
`define PSL_TO_250           3'b010
`define PSL_TO_500           3'b011
`define PSL_TO_750           3'b100
`define PSL_TO_1000          3'b101
`define PSL_TO_2000          3'b110
`define PSL_MS_100           12'd100
`define PSL_MS_250           12'd250
`define PSL_MS_500           12'd500
`define PSL_MS_750           12'd750
`define PSL_MS_1000          12'd1000
`define PSL_MS_2000          12'd2000
`define PSL_MS_NONE          12'd0

// ==========================================================
// Low pulse time: base plus step per count, in ms
`define PSL_LOW_BASE_MS      12'd350
`define PSL_LOW_STEP_MS      12'd10

// ==========================================================
// Timing base: clock in kHz, tick period in ms
`define PSL_CLK_KHZ          40000
`define PSL_TICK_MS          1
`define PSL_TICK_CYCLES      (`PSL_CLK_KHZ * `PSL_TICK_MS)

// ==========================================================
// Per-port state codes (one-hot)
`define PSL_ST_IDLE          3'b001
`define PSL_ST_MONITOR       3'b010
`define PSL_ST_LOW           3'b100

`endif

// ### psl_port_split_link_recovery.v
`timescale 1ns/1ps
`include "psl_consts.vh"

// Summary of operation
// - Only downstream ports 5 and 6 can be split.
// - Settings load by writes during configuration stage or from OTP.
// - Normal port control pin keeps driving the USB 2.0 part unchanged.
// - Enabled split activates a pin powering the SuperSpeed part.
// - No overcurrent detection on the split power pin.
// - Port 5 pin: 0x42 selects option A, 0x05 option B.
// - Port 6 pin: 0x06 selects option A, 0x04 option B.
// - Enable bits 5 and 6 enable ports 5 and 6; others reserved.
// - Global bit 0 must be set; clearing it disables all ports.
// - While enabled, each split port's link is watched continuously.
// - No valid link for the timeout toggles the split pin low.
// - Timeout timer resets and restarts whenever it expires.
// - Stuck means link state within 0x4..0x9 for the whole timeout.
// - Timeout register, OTP overridable, reset 0x05 is 1 s, 0 disables.
// - Low time set by toggle register, 400 ms default, 350 ms to 2.9 s.
// - Timeout codes: 0 never, 100/250/500/750 ms, 1 s, 2 s, 7 reserved.
// - Low time is 350 ms plus 10 ms per count; timer resets after.
module psl_port_split_link_recovery #(
  parameter TICK_CYCLES = `PSL_TICK_CYCLES
) (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       cfgStage,
  input  wire       cfgWrite,
  input  wire       cfgRead,
  input  wire [15:0] cfgAddr,
  input  wire [7:0] cfgWrData,
  output reg  [7:0] cfgRdData,
  input  wire       otpTimeoutLoad,
  input  wire [2:0] otpTimeoutValue,
  input  wire [3:0] port5LinkState,
  input  wire [3:0] port6LinkState,
  input  wire       port5PowerCtlIn,
  input  wire       port6PowerCtlIn,
  output wire       port5PowerControlPin,
  output wire       port6PowerControlPin,
  output wire       port5PinOptionAOut,
  output wire       port5PinOptionAOe,
  output wire       port5PinOptionBOut,
  output wire       port5PinOptionBOe,
  output wire       port6PinOptionAOut,
  output wire       port6PinOptionAOe,
  output wire       port6PinOptionBOut,
  output wire       port6PinOptionBOe,
  output wire       port5SplitActive,
  output wire       port6SplitActive,
  output wire       port5Toggling,
  output wire       port6Toggling
);

  // ==========================================================
  // Local constants
  localparam [2:0]  ST_IDLE     = `PSL_ST_IDLE;
  localparam [2:0]  ST_MONITOR  = `PSL_ST_MONITOR;
  localparam [2:0]  ST_LOW      = `PSL_ST_LOW;
  localparam [7:0]  TIMEOUT_RST = `PSL_RST_TIMEOUT & `PSL_MASK_TIMEOUT;
  localparam [31:0] TICK_LAST   = TICK_CYCLES - 1;

  // ==========================================================
  // Configuration registers
  reg  [7:0]  portEn_reg;
  reg  [7:0]  globalEn_reg;
  reg  [7:0]  p5PinSel_reg;
  reg  [7:0]  p6PinSel_reg;
  reg  [2:0]  timeout_reg;
  reg  [7:0]  lowTime_reg;
  wire        cfgWe;

  // Writes are only taken during the hub configuration stage
  // config stage gating
  assign cfgWe = cfgWrite & cfgStage;

  always @(posedge clock) begin
    if (!rst_n) begin
      portEn_reg   <= `PSL_RST_PORT_EN;
      globalEn_reg <= `PSL_RST_GLOBAL_EN;
      p5PinSel_reg <= `PSL_RST_PINSEL;
      p6PinSel_reg <= `PSL_RST_PINSEL;
      timeout_reg  <= TIMEOUT_RST[2:0];
      lowTime_reg  <= `PSL_RST_LOW_TIME;
    end else begin
      if (cfgWe) begin
        case (cfgAddr)
          // only ports 5 and 6 writable
          `PSL_ADDR_PORT_EN: begin
            portEn_reg <= cfgWrData & `PSL_MASK_PORT_EN;
          end
          `PSL_ADDR_GLOBAL_EN: begin
            globalEn_reg <= cfgWrData & `PSL_MASK_GLOBAL_EN;
          end
          `PSL_ADDR_P5_PINSEL: begin
            p5PinSel_reg <= cfgWrData;
          end
          `PSL_ADDR_P6_PINSEL: begin
            p6PinSel_reg <= cfgWrData;
          end
          `PSL_ADDR_LOW_TIME: begin
            lowTime_reg <= cfgWrData;
          end
          default: begin
          end
        endcase
      end
      // OTP load wins over a same-cycle register write
      // OTP overrides timeout
      if (otpTimeoutLoad) begin
        timeout_reg <= otpTimeoutValue;
      end else if (cfgWe && cfgAddr == `PSL_ADDR_TIMEOUT) begin
        timeout_reg <= cfgWrData[2:0];
      end
    end
  end

  // ==========================================================
  // Register read-back, reserved bits read zero
  reg  [7:0]  rdData_next;

  always @* begin
    rdData_next = cfgRdData;
    if (cfgRead) begin
      case (cfgAddr)
        `PSL_ADDR_PORT_EN: begin
          rdData_next = portEn_reg;
        end
        `PSL_ADDR_GLOBAL_EN: begin
          rdData_next = globalEn_reg;
        end
        `PSL_ADDR_P5_PINSEL: begin
          rdData_next = p5PinSel_reg;
        end
        `PSL_ADDR_P6_PINSEL: begin
          rdData_next = p6PinSel_reg;
        end
        `PSL_ADDR_TIMEOUT: begin
          rdData_next = {5'h00, timeout_reg};
        end
        `PSL_ADDR_LOW_TIME: begin
          rdData_next = lowTime_reg;
        end
        default: begin
          rdData_next = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      cfgRdData <= 8'h00;
    end else begin
      cfgRdData <= rdData_next;
    end
  end

  // ==========================================================
  // Millisecond tick
  reg  [31:0] tickCnt_reg;
  reg  [31:0] tickCnt_next;
  wire        msTick;

  // Free running, so the first tick of any wait may come early
  assign msTick = (tickCnt_reg == TICK_LAST);

  always @* begin
    if (msTick) begin
      tickCnt_next = 32'h00000000;
    end else begin
      tickCnt_next = tickCnt_reg + 32'h00000001;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      tickCnt_reg <= 32'h00000000;
    end else begin
      tickCnt_reg <= tickCnt_next;
    end
  end

  // ==========================================================
  // Timeout and low time decoding
  reg  [11:0] timeoutMs;
  wire [11:0] lowMs;

  always @* begin
    case (timeout_reg)
      `PSL_TO_100:  timeoutMs = `PSL_MS_100;
      `PSL_TO_250:  timeoutMs = `PSL_MS_250;
      `PSL_TO_500:  timeoutMs = `PSL_MS_500;
      `PSL_TO_750:  timeoutMs = `PSL_MS_750;
      `PSL_TO_1000: timeoutMs = `PSL_MS_1000;
      `PSL_TO_2000: timeoutMs = `PSL_MS_2000;
      default:      timeoutMs = `PSL_MS_NONE;
    endcase
  end

  assign lowMs = `PSL_LOW_BASE_MS + ({4'h0, lowTime_reg} * `PSL_LOW_STEP_MS);

  // ==========================================================
  // Per-port link watch and power toggle
  wire [1:0] portSplitOn;
  wire [3:0] linkState [0:1];
  wire [1:0] selA;
  wire [1:0] selB;
  wire [1:0] splitLevel;
  wire [1:0] toggling;
  wire [1:0] oeA;
  wire [1:0] oeB;
  wire [1:0] outA;
  wire [1:0] outB;

  assign portSplitOn[0] = portEn_reg[`PSL_BIT_PORT5] & globalEn_reg[`PSL_BIT_GLOBAL];
  assign portSplitOn[1] = portEn_reg[`PSL_BIT_PORT6] & globalEn_reg[`PSL_BIT_GLOBAL];
  assign linkState[0]   = port5LinkState;
  assign linkState[1]   = port6LinkState;
  assign selA[0] = (p5PinSel_reg == `PSL_P5_SEL_A);
  assign selB[0] = (p5PinSel_reg == `PSL_P5_SEL_B);
  assign selA[1] = (p6PinSel_reg == `PSL_P6_SEL_A);
  assign selB[1] = (p6PinSel_reg == `PSL_P6_SEL_B);

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_port
      reg  [2:0]  state_reg;
      reg  [2:0]  state_next;
      reg  [11:0] msCnt_reg;
      reg  [11:0] msCnt_next;
      wire        stuck;

      // Moving among the stuck states still counts as stuck
      // non-operational state window
      assign stuck = (linkState[gp] >= `PSL_STUCK_LO) && (linkState[gp] <= `PSL_STUCK_HI);

      always @* begin
        state_next = state_reg;
        msCnt_next = msCnt_reg;
        case (state_reg)
          ST_IDLE: begin
            msCnt_next = 12'd0;
            if (portSplitOn[gp]) begin
              state_next = ST_MONITOR;
            end
          end
          ST_MONITOR: begin
            if (!portSplitOn[gp]) begin
              state_next = ST_IDLE;
              msCnt_next = 12'd0;
            end else if (!stuck || timeoutMs == `PSL_MS_NONE) begin
              msCnt_next = 12'd0;
            end else if (msTick) begin
              if (msCnt_reg + 12'd1 >= timeoutMs) begin
                state_next = ST_LOW;
                msCnt_next = 12'd0;
              end else begin
                msCnt_next = msCnt_reg + 12'd1;
              end
            end
          end
          ST_LOW: begin
            // Dropping the enable ends a toggle at once
            if (!portSplitOn[gp]) begin
              state_next = ST_IDLE;
              msCnt_next = 12'd0;
            end else if (msTick) begin
              if (msCnt_reg + 12'd1 >= lowMs) begin
                state_next = ST_MONITOR;
                msCnt_next = 12'd0;
              end else begin
                msCnt_next = msCnt_reg + 12'd1;
              end
            end
          end
          default: begin
            state_next = ST_IDLE;
            msCnt_next = 12'd0;
          end
        endcase
      end

      always @(posedge clock) begin
        if (!rst_n) begin
          state_reg <= ST_IDLE;
          msCnt_reg <= 12'd0;
        end else begin
          state_reg <= state_next;
          msCnt_reg <= msCnt_next;
        end
      end

      assign toggling[gp]   = (state_reg == ST_LOW);
      assign splitLevel[gp] = ~toggling[gp];

      // selected pin driven while split is on
      // no overcurrent sense on these pins
      assign oeA[gp]  = portSplitOn[gp] & selA[gp];
      assign oeB[gp]  = portSplitOn[gp] & selB[gp];
      assign outA[gp] = oeA[gp] & splitLevel[gp];
      assign outB[gp] = oeB[gp] & splitLevel[gp];
    end
  endgenerate

  // ==========================================================
  // Pin outputs
  // USB 2.0 control passes through unchanged
  assign port5PowerControlPin = port5PowerCtlIn;
  assign port6PowerControlPin = port6PowerCtlIn;

  assign port5PinOptionAOe  = oeA[0];
  assign port5PinOptionBOe  = oeB[0];
  assign port6PinOptionAOe  = oeA[1];
  assign port6PinOptionBOe  = oeB[1];
  assign port5PinOptionAOut = outA[0];
  assign port5PinOptionBOut = outB[0];
  assign port6PinOptionAOut = outA[1];
  assign port6PinOptionBOut = outB[1];

  assign port5SplitActive = portSplitOn[0];
  assign port6SplitActive = portSplitOn[1];
  assign port5Toggling    = toggling[0];
  assign port6Toggling    = toggling[1];

endmodule // psl_port_split_link_recovery

// ### psl_port_split_link_recovery_properties.sv
`timescale 1ns/1ps
`include "psl_consts.vh"
module psl_link_recovery_chk (
  input wire        clock,
  input wire        rst_n,
  input wire        cfgStage,
  input wire        cfgWrite,
  input wire        cfgRead,
  input wire [15:0] cfgAddr,
  input wire [7:0]  cfgWrData,
  input wire [7:0]  cfgRdData,
  input wire [3:0]  port5LinkState,
  input wire        port5PowerCtlIn,
  input wire        port6PowerCtlIn,
  input wire        port5PowerControlPin,
  input wire        port6PowerControlPin,
  input wire        port5PinOptionAOut,
  input wire        port5PinOptionAOe,
  input wire        port5PinOptionBOut,
  input wire        port5PinOptionBOe,
  input wire        port6PinOptionAOe,
  input wire        port6PinOptionBOe,
  input wire        port5SplitActive,
  input wire        port6SplitActive,
  input wire        port5Toggling,
  input wire        port6Toggling
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ========
  // Assertions
  chk_ctl_follow: assert property (
    port5PowerControlPin == port5PowerCtlIn && port6PowerControlPin == port6PowerCtlIn)
    else $error("control pin differs");
  chk_oe_active: assert property (
    (port5PinOptionAOe || port5PinOptionBOe) |-> port5SplitActive) else $error("pin driven while off");
  chk_oe_single: assert property (
    !(port5PinOptionAOe && port5PinOptionBOe) && !(port6PinOptionAOe && port6PinOptionBOe))
    else $error("two options driven");
  chk_global_off: assert property (
    cfgStage && cfgWrite && cfgAddr == `PSL_ADDR_GLOBAL_EN && !cfgWrData[0]
    |=> !port5SplitActive && !port6SplitActive) else $error("split stays on");
  chk_toggle_low: assert property (
    port5Toggling |-> !port5PinOptionAOut && !port5PinOptionBOut) else $error("pin high in toggle");
  chk_idle_high: assert property (
    !port5Toggling && (port5PinOptionAOe || port5PinOptionBOe)
    |-> (port5PinOptionAOut || !port5PinOptionAOe) && (port5PinOptionBOut || !port5PinOptionBOe))
    else $error("idle pin low");
  chk_toggle_cause: assert property (
    $rose(port5Toggling) |-> $past(port5LinkState) >= `PSL_STUCK_LO && $past(port5LinkState) <= `PSL_STUCK_HI)
    else $error("toggle without stuck link");
  chk_quiet_off: assert property (
    !port6SplitActive && !$past(port6SplitActive) |-> !port6Toggling) else $error("toggle while off");
  chk_reserved_zero: assert property (
    cfgRead && cfgAddr == `PSL_ADDR_PORT_EN |=> (cfgRdData & 8'h9f) == 8'h00) else $error("reserved bit set");
  cover property ($rose(port5Toggling));
  cover property ($fell(port5Toggling));
  cover property (port6PinOptionBOe);
endmodule // psl_link_recovery_chk

bind psl_port_split_link_recovery psl_link_recovery_chk i_chk (.clock, .rst_n, .cfgStage, .cfgWrite,
  .cfgRead, .cfgAddr, .cfgWrData, .cfgRdData, .port5LinkState, .port5PowerCtlIn, .port6PowerCtlIn,
  .port5PowerControlPin, .port6PowerControlPin, .port5PinOptionAOut, .port5PinOptionAOe,
  .port5PinOptionBOut, .port5PinOptionBOe, .port6PinOptionAOe, .port6PinOptionBOe,
  .port5SplitActive, .port6SplitActive, .port5Toggling, .port6Toggling);

// ### psl_ss_device_model.sv
`timescale 1ns/1ps
module psl_ss_device_model (
  input  wire       clock,
  input  wire       powerPin,
  input  wire       stuckMode,
  output logic [3:0] linkState
);
  logic [4:0] ageReg = 5'h00;
  initial linkState = 4'h4;
  // ========
  // Link training
  // stuck link states
  always @(posedge clock) begin
    if (!powerPin) begin
      ageReg <= 5'h00;
      linkState <= 4'h4;
    end else begin
      if (ageReg != 5'h1f) ageReg <= ageReg + 5'h01;
      if (ageReg == 5'h08) linkState <= 4'h5;
      if (ageReg == 5'h1f) linkState <= stuckMode ? 4'h7 : 4'h0;
    end
  end
endmodule // psl_ss_device_model

// ### tb_port_split_link_recovery.sv
`timescale 1ns/1ps
`include "psl_consts.vh"
module tb_port_split_link_recovery;
  localparam int T = 4;
  logic clock = 1'b0, rst_n = 1'b0, cfgStage = 1'b1, cfgWrite = 1'b0, cfgRead = 1'b0;
  logic otpTimeoutLoad = 1'b0, port5PowerCtlIn = 1'b0, port6PowerCtlIn = 1'b0, stuckMode = 1'b0;
  logic [15:0] cfgAddr = 16'h0000;
  logic [7:0]  cfgWrData = 8'h00;
  logic [2:0]  otpTimeoutValue = 3'h0;
  logic [3:0]  port6LinkState = 4'h0;
  wire  [7:0]  cfgRdData;
  wire  [3:0]  port5LinkState;
  wire port5PowerControlPin, port6PowerControlPin, port5SplitActive, port6SplitActive, port5Toggling, port6Toggling;
  wire port5PinOptionAOut, port5PinOptionAOe, port5PinOptionBOut, port5PinOptionBOe;
  wire port6PinOptionAOut, port6PinOptionAOe, port6PinOptionBOut, port6PinOptionBOe;
  wire splitPower5 = port5PinOptionAOe ? port5PinOptionAOut : (port5PinOptionBOe & port5PinOptionBOut);
  wire [3:0] pinOe = {port5PinOptionAOe, port5PinOptionBOe, port6PinOptionAOe, port6PinOptionBOe};
  wire [3:0] pinOut = {port5PinOptionAOut, port5PinOptionBOut, port6PinOptionAOut, port6PinOptionBOut};
  logic [15:0] regAddr [6] = '{`PSL_ADDR_PORT_EN, `PSL_ADDR_GLOBAL_EN, `PSL_ADDR_P5_PINSEL,
    `PSL_ADDR_P6_PINSEL, `PSL_ADDR_TIMEOUT, `PSL_ADDR_LOW_TIME};
  logic [7:0] regRst [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05};
  logic [7:0] regMask [6] = '{8'h60, 8'h01, 8'hff, 8'hff, 8'h07, 8'hff};
  logic [2:0] toCode [6] = '{`PSL_TO_100, `PSL_TO_250, `PSL_TO_500, `PSL_TO_750, `PSL_TO_1000, `PSL_TO_2000};
  int toMs [6] = '{100, 250, 500, 750, 1000, 2000};
  int mismatches = 0, checked = 0, cnt, lowTicks;
  always #12.5 clock = ~clock;
  psl_port_split_link_recovery #(.TICK_CYCLES(T)) i_dut (.clock, .rst_n, .cfgStage, .cfgWrite,
    .cfgRead, .cfgAddr, .cfgWrData, .cfgRdData, .otpTimeoutLoad, .otpTimeoutValue, .port5LinkState,
    .port6LinkState, .port5PowerCtlIn, .port6PowerCtlIn, .port5PowerControlPin, .port6PowerControlPin,
    .port5PinOptionAOut, .port5PinOptionAOe, .port5PinOptionBOut, .port5PinOptionBOe,
    .port6PinOptionAOut, .port6PinOptionAOe, .port6PinOptionBOut, .port6PinOptionBOe,
    .port5SplitActive, .port6SplitActive, .port5Toggling, .port6Toggling);
  psl_ss_device_model i_dev (.clock, .powerPin(splitPower5), .stuckMode, .linkState(port5LinkState));
  // ========
  // Tasks
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cfgAddr = a;
    cfgWrData = d;
    cfgWrite = 1'b1;
    @(negedge clock);
    cfgWrite = 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    cfgAddr = a;
    cfgRead = 1'b1;
    @(negedge clock);
    cfgRead = 1'b0;
    @(negedge clock);
    check("readData", exp, cfgRdData);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ========
  // Tests
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    foreach (regAddr[i]) rd(regAddr[i], regRst[i]);
    foreach (regAddr[i]) begin
      wr(regAddr[i], 8'hff);
      rd(regAddr[i], regMask[i]);
      wr(regAddr[i], regRst[i]);
    end
    rd(16'h1234, 8'h00);
    cfgStage = 1'b0;
    wr(`PSL_ADDR_PORT_EN, 8'h60);
    cfgStage = 1'b1;
    rd(`PSL_ADDR_PORT_EN, 8'h00);
    otpTimeoutValue = `PSL_TO_250;
    otpTimeoutLoad = 1'b1;
    @(negedge clock);
    otpTimeoutLoad = 1'b0;
    rd(`PSL_ADDR_TIMEOUT, 8'h02);
    for (int k = 0; k < 4; k++) begin
      {port6PowerCtlIn, port5PowerCtlIn} = k[1:0];
      @(negedge clock);
      check("portCtl", {6'h00, port6PowerCtlIn, port5PowerCtlIn}, {6'h00, port6PowerControlPin, port5PowerControlPin});
    end
    wr(`PSL_ADDR_PORT_EN, 8'h60);
    wr(`PSL_ADDR_GLOBAL_EN, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(`PSL_ADDR_P5_PINSEL, k ? `PSL_P5_SEL_B : `PSL_P5_SEL_A);
      wr(`PSL_ADDR_P6_PINSEL, k ? `PSL_P6_SEL_B : `PSL_P6_SEL_A);
      check("pinOe", k ? 8'h05 : 8'h0a, {4'h0, pinOe});
      check("pinOut", k ? 8'h05 : 8'h0a, {4'h0, pinOut});
    end
    wr(`PSL_ADDR_GLOBAL_EN, 8'h00);
    check("offState", 8'h00, {2'h0, port6SplitActive, port5SplitActive, pinOe});
    wr(`PSL_ADDR_GLOBAL_EN, 8'h01);
    wr(`PSL_ADDR_TIMEOUT, {5'h00, `PSL_TO_100});
    repeat (110 * T) @(negedge clock);
    check("healthyLink", 8'h00, {7'h00, port5Toggling});
    for (int r = 0; r < 6; r++) begin
      wr(`PSL_ADDR_TIMEOUT, {5'h00, toCode[r]});
      wr(`PSL_ADDR_LOW_TIME, r ? 8'h00 : 8'h05);
      lowTicks = r ? 350 : 400;
      stuckMode = 1'b1;
      cnt = 0;
      while (!port5Toggling && cnt < 2100 * T) begin
        @(negedge clock);
        cnt++;
      end
      check("timeoutCycles", 8'h01, {7'h00, cnt >= (toMs[r] - 1) * T && cnt <= toMs[r] * T + 4});
      cnt = 0;
      while (port5Toggling && cnt < 2000) begin
        @(negedge clock);
        cnt++;
      end
      check("lowCycles", 8'h01, {7'h00, cnt >= (lowTicks - 1) * T && cnt <= (lowTicks + 1) * T});
    end
    for (int k = 0; k < 2; k++) begin
      wr(`PSL_ADDR_TIMEOUT, k ? 8'h07 : 8'h00);
      repeat (110 * T) @(negedge clock);
      check("toggleOff", 8'h00, {6'h00, port6Toggling, port5Toggling});
    end
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge clock);
    mismatches++;
    complete_run();
  end
endmodule // tb_port_split_link_recovery
